// ==== include/srvs_pkg.sv ====
// constants for the slave registration verify status block
package srvs_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [7:0] SRVS_IDX_OUT_MISS  = 8'h06;
  localparam logic [7:0] SRVS_IDX_IN_MISS   = 8'h07;
  localparam logic [7:0] SRVS_IDX_OUT_UNREG = 8'h08;
  localparam logic [7:0] SRVS_IDX_IN_UNREG  = 8'h09;
  localparam logic [7:0] SRVS_IDX_OUT_TABLE = 8'h10;
  localparam logic [7:0] SRVS_IDX_IN_TABLE  = 8'h11;
  localparam logic [7:0] SRVS_IDX_MON_TIME  = 8'h12;
  localparam logic [7:0] SRVS_IDX_CTRL      = 8'h13;
  localparam logic [7:0] SRVS_IDX_IRQ_STAT  = 8'h14;
  localparam logic [7:0] SRVS_IDX_IRQ_MASK  = 8'h15;
  localparam int unsigned SRVS_ADDR_W = 10;
  localparam int unsigned SRVS_NODES  = 16;
  // ***************
  // field layout
  // ***************
  localparam int unsigned SRVS_CTRL_RESTART = 0;
  localparam int unsigned SRVS_STAT_ENABLED = 1;
  localparam int unsigned SRVS_STAT_ARMED   = 2;
  localparam int unsigned SRVS_IRQ_OUT_MISS  = 0;
  localparam int unsigned SRVS_IRQ_IN_MISS   = 1;
  localparam int unsigned SRVS_IRQ_OUT_UNREG = 2;
  localparam int unsigned SRVS_IRQ_IN_UNREG  = 3;
  localparam int unsigned SRVS_IRQ_W         = 4;
  // ***************
  // reset values and timing
  // ***************
  localparam logic [15:0] SRVS_TABLE_RST = 16'h0000;
  localparam logic [15:0] SRVS_MON_RST   = 16'h000a;
  localparam int unsigned SRVS_CLK_MHZ   = 200;
  localparam int unsigned SRVS_TICK_US   = 1000;
  localparam int unsigned SRVS_TICK_CYC  = SRVS_CLK_MHZ * SRVS_TICK_US;
  localparam logic [1:0]  SRVS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  SRVS_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    SRVS_ST_LOAD = 2'h0,
    SRVS_ST_WAIT = 2'h1,
    SRVS_ST_RUN  = 2'h2,
    SRVS_ST_IDLE = 2'h3
  } srvs_state_t;
endpackage : srvs_pkg

// ==== rtl/srvs_tick.sv ====
// millisecond enable divider for the monitoring timer
`timescale 1ns/1ps
`default_nettype none
module srvs_tick
  import srvs_pkg::*;
#(
  parameter int unsigned TICK_CYC = SRVS_TICK_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clear,
  output logic      tick
);
  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(TICK_CYC - 1));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= (clear || wrap) ? 32'h0 : cnt_q + 32'h1;
      tick  <= wrap && !clear;
    end
  end
endmodule : srvs_tick
`default_nettype wire

// ==== rtl/srvs_top.sv ====
// slave registration verification status words with ahb-lite access
`timescale 1ns/1ps
`default_nettype none
// Contract
// - with checking active, a registered output node that is absent sets its output-missing bit.
// - with checking active, a registered input node that is absent sets its input-missing bit.
// - no verification bit is ever set while the registration function is disabled.
// - bits 0 to 15 of each status word map one to one onto node numbers of that slave type.
// - a missing bit clears by itself once that node joins the network.
// - with checking active, a present output node absent from its table sets its unregistered bit.
// - with checking active, a present input node absent from its table sets its unregistered bit.
// - an unregistered bit holds until power cycle or unit restart.
// - a multi-node slave sets all the node bits it occupies together.
// - tables and monitoring time are loaded only at power-up or unit restart.
// - the dip switch pin 4 enables (on) or disables (off) verification.
module srvs_top
  import srvs_pkg::*;
#(
  parameter int unsigned NODES    = SRVS_NODES,
  parameter int unsigned TICK_CYC = SRVS_TICK_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              dip_reg_enable,
  input  wire logic [NODES-1:0]  output_node_present,
  input  wire logic [NODES-1:0]  input_node_present,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   irq
);
  // ***************
  // bus address phase capture
  // ***************
  logic                   wr_pend_q;
  logic [SRVS_ADDR_W-1:0] wr_idx_q;
  wire  [31:0]            unused_hi = haddr & 32'h0;
  wire                    unused_sz = ^hsize;
  wire                    ap_valid  = hsel && hready &&
                                      (htrans == SRVS_HTRANS_NONSEQ || htrans == SRVS_HTRANS_SEQ);
  wire  [SRVS_ADDR_W-1:0] ap_idx    = haddr[SRVS_ADDR_W+1:2];

  // ***************
  // settings seen by the host and latched copies
  // ***************
  logic [NODES-1:0]  out_table_q;
  logic [NODES-1:0]  in_table_q;
  logic [15:0]       mon_time_q;
  logic [NODES-1:0]  act_out_table_q;
  logic [NODES-1:0]  act_in_table_q;
  logic [15:0]       act_mon_q;
  logic              act_enable_q;
  logic              restart_q;
  logic [15:0]       mon_cnt_q;
  srvs_state_t       state_q;
  srvs_state_t       state_d;

  // ***************
  // status words
  // ***************
  logic [NODES-1:0]       out_miss_q;
  logic [NODES-1:0]       in_miss_q;
  logic [NODES-1:0]       out_unreg_q;
  logic [NODES-1:0]       in_unreg_q;
  logic [SRVS_IRQ_W-1:0]  irq_stat_q;
  logic [SRVS_IRQ_W-1:0]  irq_mask_q;

  // ***************
  // write decode
  // ***************
  // one index compare shared by the write and read decoders
  function automatic logic srvs_hit(input logic [SRVS_ADDR_W-1:0] idx,
                                    input logic [7:0]             reg_idx);
    srvs_hit = (idx == SRVS_ADDR_W'(reg_idx));
  endfunction

  wire wr_out_table = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_OUT_TABLE);
  wire wr_in_table  = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_IN_TABLE);
  wire wr_mon_time  = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_MON_TIME);
  wire wr_ctrl      = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_CTRL);
  wire wr_irq_stat  = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_IRQ_STAT);
  wire wr_irq_mask  = wr_pend_q && srvs_hit(wr_idx_q, SRVS_IDX_IRQ_MASK);
  // restart: self-clearing strobe, reloads settings like a power-up
  wire restart_req  = wr_ctrl && hwdata[SRVS_CTRL_RESTART];

  // ***************
  // verification terms
  // ***************
  wire tick;
  wire checking   = (state_q == SRVS_ST_RUN);
  wire mon_done   = (mon_cnt_q >= act_mon_q);
  // per node compare; a multi-node slave reports each of its nodes absent
  // or present, so all its bits move together
  wire [NODES-1:0] out_miss_d = checking ? (act_out_table_q & ~output_node_present)
                                         : out_miss_q;
  wire [NODES-1:0] in_miss_d  = checking ? (act_in_table_q & ~input_node_present)
                                         : in_miss_q;
  wire [NODES-1:0] out_unreg_set = (state_q == SRVS_ST_WAIT || checking) && act_enable_q
                                   ? (output_node_present & ~act_out_table_q)
                                   : {NODES{1'b0}};
  wire [NODES-1:0] in_unreg_set  = (state_q == SRVS_ST_WAIT || checking) && act_enable_q
                                   ? (input_node_present & ~act_in_table_q)
                                   : {NODES{1'b0}};
  wire [NODES-1:0] out_miss_new  = out_miss_d & ~out_miss_q;
  wire [NODES-1:0] in_miss_new   = in_miss_d & ~in_miss_q;
  wire [NODES-1:0] out_unreg_new = out_unreg_set & ~out_unreg_q;
  wire [NODES-1:0] in_unreg_new  = in_unreg_set & ~in_unreg_q;
  logic [SRVS_IRQ_W-1:0] irq_ev;
  always_comb
  begin
    irq_ev                     = '0;
    irq_ev[SRVS_IRQ_OUT_MISS]  = |out_miss_new;
    irq_ev[SRVS_IRQ_IN_MISS]   = |in_miss_new;
    irq_ev[SRVS_IRQ_OUT_UNREG] = |out_unreg_new;
    irq_ev[SRVS_IRQ_IN_UNREG]  = |in_unreg_new;
  end
  // set wins over write-one-to-clear
  wire [SRVS_IRQ_W-1:0] irq_stat_d = irq_ev |
                                     (irq_stat_q & ~(wr_irq_stat ? hwdata[SRVS_IRQ_W-1:0]
                                                                 : {SRVS_IRQ_W{1'b0}}));

  // ***************
  // startup sequencer
  // ***************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SRVS_ST_LOAD: state_d = act_enable_q ? SRVS_ST_WAIT : SRVS_ST_IDLE;
      SRVS_ST_WAIT: if (mon_done) state_d = SRVS_ST_RUN;
      SRVS_ST_RUN:  state_d = SRVS_ST_RUN;
      SRVS_ST_IDLE: state_d = SRVS_ST_IDLE;
    endcase
    if (restart_q)
      state_d = SRVS_ST_LOAD;
  end

  srvs_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .clear (state_q != SRVS_ST_WAIT),
    .tick  (tick)
  );

  // ***************
  // host settings and bus pipeline
  // ***************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q   <= 1'b0;
      wr_idx_q    <= '0;
      out_table_q <= SRVS_TABLE_RST[NODES-1:0];
      in_table_q  <= SRVS_TABLE_RST[NODES-1:0];
      mon_time_q  <= SRVS_MON_RST;
      irq_mask_q  <= '0;
      restart_q   <= 1'b1;
    end
    else
    begin
      wr_pend_q <= ap_valid && hwrite;
      wr_idx_q  <= ap_idx;
      restart_q <= restart_req;
      // tables may change at any time, but only take hold on restart
      if (wr_out_table) out_table_q <= hwdata[NODES-1:0];
      if (wr_in_table)  in_table_q  <= hwdata[NODES-1:0];
      if (wr_mon_time)  mon_time_q  <= hwdata[15:0];
      if (wr_irq_mask)  irq_mask_q  <= hwdata[SRVS_IRQ_W-1:0];
    end
  end

  // ***************
  // latched settings and timers
  // ***************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_out_table_q <= '0;
      act_in_table_q  <= '0;
      act_mon_q       <= '0;
      act_enable_q    <= 1'b0;
      mon_cnt_q       <= '0;
      state_q         <= SRVS_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
      if (restart_q)
      begin
        act_out_table_q <= out_table_q;
        act_in_table_q  <= in_table_q;
        act_mon_q       <= mon_time_q;
        act_enable_q    <= dip_reg_enable;
        mon_cnt_q       <= '0;
      end
      else if (state_q == SRVS_ST_WAIT && tick && !mon_done)
        mon_cnt_q <= mon_cnt_q + 16'h1;
    end
  end

  // ***************
  // status words and interrupt
  // ***************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_miss_q  <= '0;
      in_miss_q   <= '0;
      out_unreg_q <= '0;
      in_unreg_q  <= '0;
      irq_stat_q  <= '0;
      irq         <= 1'b0;
    end
    else if (restart_q)
    begin
      out_miss_q  <= '0;
      in_miss_q   <= '0;
      out_unreg_q <= '0;
      in_unreg_q  <= '0;
      irq_stat_q  <= '0;
      irq         <= 1'b0;
    end
    else
    begin
      out_miss_q  <= out_miss_d;
      in_miss_q   <= in_miss_d;
      out_unreg_q <= out_unreg_q | out_unreg_set;
      in_unreg_q  <= in_unreg_q | in_unreg_set;
      irq_stat_q  <= irq_stat_d;
      irq         <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ***************
  // read path
  // ***************
  wire sel_out_miss  = srvs_hit(ap_idx, SRVS_IDX_OUT_MISS);
  wire sel_in_miss   = srvs_hit(ap_idx, SRVS_IDX_IN_MISS);
  wire sel_out_unreg = srvs_hit(ap_idx, SRVS_IDX_OUT_UNREG);
  wire sel_in_unreg  = srvs_hit(ap_idx, SRVS_IDX_IN_UNREG);
  wire sel_out_table = srvs_hit(ap_idx, SRVS_IDX_OUT_TABLE);
  wire sel_in_table  = srvs_hit(ap_idx, SRVS_IDX_IN_TABLE);
  wire sel_mon_time  = srvs_hit(ap_idx, SRVS_IDX_MON_TIME);
  wire sel_ctrl      = srvs_hit(ap_idx, SRVS_IDX_CTRL);
  wire sel_irq_stat  = srvs_hit(ap_idx, SRVS_IDX_IRQ_STAT);
  wire sel_irq_mask  = srvs_hit(ap_idx, SRVS_IDX_IRQ_MASK);

  // restart strobe bit reads back as zero
  wire [31:0] ctrl_rd = (32'(act_enable_q) << SRVS_STAT_ENABLED) |
                        (32'(act_enable_q & checking) << SRVS_STAT_ARMED);
  wire [31:0] rd_mux =
    sel_out_miss  ? 32'(out_miss_q)  :
    sel_in_miss   ? 32'(in_miss_q)   :
    sel_out_unreg ? 32'(out_unreg_q) :
    sel_in_unreg  ? 32'(in_unreg_q)  :
    sel_out_table ? 32'(out_table_q) :
    sel_in_table  ? 32'(in_table_q)  :
    sel_mon_time  ? 32'(mon_time_q)  :
    sel_ctrl      ? ctrl_rd          :
    sel_irq_stat  ? 32'(irq_stat_q)  :
    sel_irq_mask  ? 32'(irq_mask_q)  :
    32'h0 | unused_hi | 32'(unused_sz & 1'b0);

  // zero wait states; unmapped reads return zero, writes ignored
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_valid && !hwrite)
        hrdata <= rd_mux;
    end
  end
endmodule : srvs_top
`default_nettype wire

// ==== test/srvs_nodes.sv ====
// behavioural remote slave nodes joining and leaving the network
`timescale 1ns/1ps
`default_nettype none
module srvs_nodes #(
  parameter int unsigned DLY = 3
) (
  input  wire logic        clock,
  input  wire logic [15:0] want_o,
  input  wire logic [15:0] want_i,
  output logic      [15:0] out_present,
  output logic      [15:0] in_present
);
  logic [15:0] po [DLY] = '{default: '0};
  logic [15:0] pi [DLY] = '{default: '0};
  // 16-point slave at node 4, 32-point slave at node 8
  function automatic logic [15:0] span(input logic [15:0] w);
    span = w;
    span[5] = w[4] | w[5];
    span[11:9] = w[11:9] | {3{w[8]}};
  endfunction
  // joins and leaves both show only after a DLY-edge link delay
  always @(posedge clock)
  begin
    po[0] <= span(want_o);
    pi[0] <= span(want_i);
    for (int k = 1; k < DLY; k++)
    begin
      po[k] <= po[k-1];
      pi[k] <= pi[k-1];
    end
  end
  assign out_present = po[DLY-1];
  assign in_present  = pi[DLY-1];
endmodule // srvs_nodes
`default_nettype wire

// ==== test/srvs_chk_sva.sv ====
// port assertions for the verify status block
`timescale 1ns/1ps
`default_nettype none
module srvs_chk
  import srvs_pkg::*;
#(
  parameter int unsigned NODES    = SRVS_NODES,
  parameter int unsigned TICK_CYC = SRVS_TICK_CYC
) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             dip_reg_enable,
  input wire logic [NODES-1:0] output_node_present,
  input wire logic [NODES-1:0] input_node_present,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic             irq
);
  logic       rd_q, wr_q, en_q, boot_q;
  logic [7:0] idx_q;
  logic [3:0] stab_q;
  wire req     = hsel && hready && htrans[1];
  wire stat_rd = rd_q && idx_q >= SRVS_IDX_OUT_MISS && idx_q <= SRVS_IDX_IN_UNREG;
  wire unmap   = rd_q && !(idx_q inside {[8'h06:8'h09], [8'h10:8'h15]});
  wire rstrt   = wr_q && idx_q == SRVS_IDX_CTRL && hwdata[SRVS_CTRL_RESTART];
  // mirror of the enable latched at each restart
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {rd_q, wr_q, en_q, boot_q} <= 4'h1;
      idx_q  <= 8'h00;
      stab_q <= 4'h0;
    end
    else
    begin
      rd_q   <= req && !hwrite;
      wr_q   <= req && hwrite;
      idx_q  <= req ? haddr[9:2] : idx_q;
      boot_q <= 1'b0;
      en_q   <= (boot_q || rstrt) ? dip_reg_enable : en_q;
      stab_q <= !($stable(output_node_present) && $stable(input_node_present)) ? 4'h0 :
                (stab_q == 4'hf) ? stab_q : stab_q + 4'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_ready_high: assert property (hreadyout) else $error("wait state inserted");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_unmapped_zero: assert property (unmap |-> hrdata == 32'h0) else $error("unmapped data");
  chk_word_width: assert property (stat_rd |-> hrdata[31:16] == 16'h0)
    else $error("status upper bits set");
  chk_disabled_quiet: assert property (stat_rd && !en_q |-> hrdata == 32'h0)
    else $error("status set while disabled");
  chk_out_miss_absent: assert property (rd_q && idx_q == SRVS_IDX_OUT_MISS && stab_q > 4'h3
    |-> (hrdata[NODES-1:0] & output_node_present) == '0) else $error("present node missing");
  chk_in_miss_absent: assert property (rd_q && idx_q == SRVS_IDX_IN_MISS && stab_q > 4'h3
    |-> (hrdata[NODES-1:0] & input_node_present) == '0) else $error("present node missing");
  chk_rdata_holds: assert property (!(req && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  chk_irq_quiet: assert property (!en_q [*3] |-> !irq) else $error("irq while disabled");
  cover property (stat_rd && en_q && hrdata != 32'h0);
  cover property (irq);
  cover property (unmap);
endmodule // srvs_chk
bind srvs_top srvs_chk #(.NODES(NODES), .TICK_CYC(TICK_CYC)) u_chk (.clock(clock),
  .rst_n(rst_n), .dip_reg_enable(dip_reg_enable), .output_node_present(output_node_present),
  .input_node_present(input_node_present), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the verify status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import srvs_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, dip = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0]  htrans = 2'h0;
  logic [15:0] want_o = '0, want_i = '0, tbl_o, tbl_i, lt_o = '0, lt_i = '0, ur_o = '0, ur_i = '0;
  logic [15:0] pr_o, pr_i;
  logic [3:0]  ev;
  logic        on = 1'b0, rd_dp = 1'b0;
  wire  logic [31:0] hrdata;
  wire  logic  hreadyout, hresp, irq;
  logic [31:0] exp_q [$];
  int          seed = 33, fails = 0, samples_checked = 0, cyc = 0;
  always #2.5 clock = ~clock;
  srvs_nodes nodes (.clock(clock), .want_o(want_o), .want_i(want_i), .out_present(pr_o),
    .in_present(pr_i));
  srvs_top #(.TICK_CYC(4)) uut (.clock(clock), .rst_n(rst_n), .dip_reg_enable(dip),
    .output_node_present(pr_o), .input_node_present(pr_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  function automatic logic [15:0] span(input logic [15:0] w);
    span = w;
    span[5] = w[4] | w[5];
    span[11:9] = w[11:9] | {3{w[8]}};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ***************
  // bus master
  // ***************
  task automatic ahb(input logic [7:0] idx, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= SRVS_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(idx, 1'b0, 32'h0);
  endtask
  task automatic tables(input logic [15:0] o, input logic [15:0] i);
    tbl_o = o;
    tbl_i = i;
    ahb(SRVS_IDX_OUT_TABLE, 1'b1, {16'h0, o});
    ahb(SRVS_IDX_IN_TABLE, 1'b1, {16'h0, i});
  endtask
  task automatic restart(input logic en);
    dip <= en;
    ahb(SRVS_IDX_CTRL, 1'b1, 32'h1);
    // the reload lands one edge after the write; status is stale until then
    repeat (2) @(posedge clock);
    on = en;
    lt_o = en ? tbl_o : 16'h0;
    lt_i = en ? tbl_i : 16'h0;
    ur_o = 16'h0;
    ur_i = 16'h0;
  endtask
  task automatic verify();
    if (on)
    begin
      ur_o = ur_o | (span(want_o) & ~lt_o);
      ur_i = ur_i | (span(want_i) & ~lt_i);
    end
    rd(SRVS_IDX_OUT_MISS, {16'h0, lt_o & ~span(want_o)});
    rd(SRVS_IDX_IN_MISS, {16'h0, lt_i & ~span(want_i)});
    rd(SRVS_IDX_OUT_UNREG, {16'h0, ur_o});
    rd(SRVS_IDX_IN_UNREG, {16'h0, ur_i});
  endtask
  // read data is taken at the edge that ends the data phase
  always @(posedge clock)
  begin
    if (rd_dp && hreadyout === 1'b1)
      check(hrdata, exp_q.pop_front());
    rd_dp <= hsel && htrans == SRVS_HTRANS_NONSEQ && !hwrite && hreadyout;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    tables(16'($random(seed)), 16'($random(seed)));
    ahb(SRVS_IDX_MON_TIME, 1'b1, 32'h5);
    rd(SRVS_IDX_MON_TIME, 32'h5);
    want_o <= 16'($random(seed));
    want_i <= 16'($random(seed));
    repeat (30) @(posedge clock);
    verify();
    rd(8'h0f, 32'h0);
    restart(1'b1);
    rd(SRVS_IDX_OUT_MISS, 32'h0);
    rd(SRVS_IDX_CTRL, 32'h2);
    repeat (60) @(posedge clock);
    ahb(SRVS_IDX_IN_UNREG, 1'b1, 32'h0);
    verify();
    ev = {|ur_i, |ur_o, |(lt_i & ~span(want_i)), |(lt_o & ~span(want_o))};
    ahb(SRVS_IDX_IRQ_MASK, 1'b1, 32'hf);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, {31'h0, |ev});
    rd(SRVS_IDX_IRQ_STAT, {28'h0, ev});
    ahb(SRVS_IDX_IRQ_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    ahb(SRVS_IDX_IRQ_STAT, 1'b1, 32'hf);
    rd(SRVS_IDX_IRQ_STAT, 32'h0);
    // new tables must not apply before a restart
    tables(16'hffff, 16'hffff);
    want_o <= 16'hffff;
    want_i <= 16'hffff;
    repeat (20) @(posedge clock);
    verify();
    want_o <= 16'h0;
    want_i <= 16'h0;
    repeat (20) @(posedge clock);
    verify();
    restart(1'b1);
    rd(SRVS_IDX_OUT_UNREG, 32'h0);
    repeat (60) @(posedge clock);
    verify();
    rd(SRVS_IDX_CTRL, 32'h6);
    restart(1'b0);
    want_o <= 16'($random(seed));
    repeat (60) @(posedge clock);
    verify();
    rd(SRVS_IDX_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
